// *** rtl/spm_regs.svh ***
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define SPM_CFG_OFS 8'h00
`define SPM_BAUD_OFS 8'h04
`define SPM_DLY_OFS 8'h08
`define SPM_TX_OFS 8'h0C
`define SPM_RX_OFS 8'h10
`define SPM_STAT_OFS 8'h14
`define SPM_STN_OFS 8'h18
// ---------------------------------------------
// Fields and reset values
// ---------------------------------------------
`define SPM_CFG_PROTO 1:0
`define SPM_CFG_ASCII 2
`define SPM_CFG_PAR 4:3
`define SPM_CFG_STOP2 5
`define SPM_CFG_DATA7 6
`define SPM_CFG_XON 7
`define SPM_CFG_RTSFC 8
`define SPM_CFG_ECHO 9
`define SPM_CFG_MASK 32'h0000_03FF
`define SPM_CFG_RST 32'h0000_0010
`define SPM_DLY_ON 7:0
`define SPM_DLY_OFF 15:8
`define SPM_DLY_MULT 19:16
`define SPM_DLY_MASK 32'h000F_FFFF
`define SPM_DLY_RST 32'h0001_0000
`define SPM_TX_LAST 8
`define SPM_ST_ERR 3
`define SPM_ST_PERR 4
`define SPM_ST_FERR 5
`define SPM_STN_RST 8'h01
`define SPM_STN_MAX_NET 8'h5A
`define SPM_STN_MAX_MB 8'hF7
`define SPM_XON_CHAR 8'h11
`define SPM_XOFF_CHAR 8'h13
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define SPM_CLK_HZ 25000000
`define SPM_CLK_NS 40
`define SPM_MS_NS 1000000
`define SPM_NET_TMO_MS 800
`define SPM_MB_TMO_MS 500
`define SPM_RAW_TMO_CHARS 3
`define SPM_BAUD_MIN 300
`define SPM_BAUD_MAX 115200
`define SPM_BAUD_DEF 19200
`endif

// *** rtl/spm_pkg.sv ***
// ---------------------------------------------
// Types
// ---------------------------------------------
package spm_pkg;
  typedef enum logic [4:0] {
    SPM_IDLE = 5'h01,
    SPM_RTS_ON = 5'h02,
    SPM_SEND = 5'h04,
    SPM_RTS_OFF = 5'h08,
    SPM_WAIT = 5'h10
  } spm_state_t;
  typedef enum logic [1:0] {
    SPM_PROTO_NET = 2'h0,
    SPM_PROTO_MODBUS = 2'h1,
    SPM_PROTO_RAW = 2'h2
  } spm_proto_t;
  typedef enum logic [1:0] {
    SPM_PAR_NONE = 2'h0,
    SPM_PAR_EVEN = 2'h1,
    SPM_PAR_ODD = 2'h2
  } spm_parity_t;
endpackage : spm_pkg

// *** rtl/spm_serial_port.sv ***
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Wait on-delay after raising RTS before data
// - Wait off-delay after last data, then drop RTS
// - Await response up to timeout, else log error
// - Base timeout 800 ms, 500 ms, three characters
// - Slave at reset, master only during host transactions
// - Modbus addresses 1..247 extended, 1..90 basic
// - Bit rates 300 to 115.2K, same everywhere
// - One or two stop bits per frame
// - Parity none, even or odd, generated and checked
// - Raw mode uses seven or eight data bits
// - Message data in hex or ASCII format
// - Raw mode passes unframed ASCII strings
// - XON and XOFF resume and pause transmission
// - RTS flow control gates transmission
// - Echo suppression discards own characters
`include "spm_regs.svh"
module spm_serial_port
  import spm_pkg::*;
#(
  parameter int MS_CYCLES = `SPM_MS_NS / `SPM_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  input wire logic cts_in,
  output logic txd,
  output logic rts_out
);
  // ---------------------------------------------
  // Constants and functions
  // ---------------------------------------------
  localparam logic [16:0] DIV_MIN = 17'((`SPM_CLK_HZ + `SPM_BAUD_MAX - 1) / `SPM_BAUD_MAX);
  localparam logic [16:0] DIV_MAX = 17'(`SPM_CLK_HZ / `SPM_BAUD_MIN);
  localparam logic [16:0] DIV_DEF = 17'(`SPM_CLK_HZ / `SPM_BAUD_DEF);
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic par_bit(input logic [7:0] d, input logic d7, input logic odd);
    return ^(d7 ? {1'h0, d[6:0]} : d) ^ odd;
  endfunction : par_bit

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? 8'(8'h30 + n) : 8'(8'h37 + n);
  endfunction : hex_char

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
  endfunction : hex_val

  function automatic logic [11:0] frame(input logic [7:0] d, input logic d7, input logic pon, input logic odd);
    logic [11:0] f;
    f = d7 ? {4'hF, d[6:0], 1'h0} : {3'h7, d, 1'h0};
    if (pon) f[d7 ? 8 : 9] = par_bit(d, d7, odd);
    return f;
  endfunction : frame

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  spm_state_t st_reg, st_next;
  logic [31:0] cfg_reg, dly_reg, wait_reg, rdata_reg;
  logic [16:0] div_reg, tx_tmr_reg, rx_tmr_reg;
  logic [15:0] ms_cnt_reg;
  logic [11:0] tx_sh_reg, rx_sh_reg;
  logic [7:0] stn_reg, awaddr_reg, tx_data_reg, rx_data_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg, tx_left_reg, rx_left_reg, rhi_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_got_reg, w_got_reg, txd_reg, rts_reg, master_reg;
  logic pend_reg, last_reg, nib_reg, rnib_reg, rx_busy_reg, rx_done_reg;
  logic rx_valid_reg, err_reg, perr_reg, ferr_reg, paused_reg;

  // ---------------------------------------------
  // Configuration decode
  // ---------------------------------------------
  wire [1:0] proto = cfg_reg[`SPM_CFG_PROTO];
  wire is_raw = proto == SPM_PROTO_RAW;
  wire ascii = cfg_reg[`SPM_CFG_ASCII] && !is_raw;
  wire [1:0] par = cfg_reg[`SPM_CFG_PAR];
  wire par_on = par == SPM_PAR_EVEN || par == SPM_PAR_ODD;
  wire par_odd = par == SPM_PAR_ODD;
  wire stop2 = cfg_reg[`SPM_CFG_STOP2];
  wire data7 = cfg_reg[`SPM_CFG_DATA7] && is_raw;
  wire xon_en = cfg_reg[`SPM_CFG_XON];
  wire rtsfc = cfg_reg[`SPM_CFG_RTSFC];
  wire echo = cfg_reg[`SPM_CFG_ECHO];
  wire [3:0] frame_bits = 4'(4'hA + {3'h0, stop2} + {3'h0, par_on} - {3'h0, data7});
  wire [3:0] mult = dly_reg[`SPM_DLY_MULT];
  wire tmo_off = mult == 4'h0;
  wire [31:0] tmo_ms = 32'((proto == SPM_PROTO_MODBUS ? `SPM_MB_TMO_MS : `SPM_NET_TMO_MS) * mult);
  wire [31:0] tmo_cnt = is_raw ? 32'(div_reg * frame_bits * `SPM_RAW_TMO_CHARS * mult) : tmo_ms;

  // ---------------------------------------------
  // Register bus decode
  // ---------------------------------------------
  wire do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
  wire [31:0] wmerge_cfg = merge(cfg_reg, wdata_reg, wstrb_reg);
  wire [31:0] wmerge_dly = merge(dly_reg, wdata_reg, wstrb_reg);
  wire [31:0] wmerge_div = merge({15'h0, div_reg}, wdata_reg, wstrb_reg);
  wire [7:0] wmerge_stn = wstrb_reg[0] ? wdata_reg[7:0] : stn_reg;
  wire [7:0] stn_max = (proto == SPM_PROTO_NET) ? `SPM_STN_MAX_NET : `SPM_STN_MAX_MB;
  wire wr_cfg = do_wr && awaddr_reg == `SPM_CFG_OFS;
  wire wr_dly = do_wr && awaddr_reg == `SPM_DLY_OFS;
  wire wr_baud = do_wr && awaddr_reg == `SPM_BAUD_OFS;
  wire wr_stn = do_wr && awaddr_reg == `SPM_STN_OFS;
  wire wr_tx = do_wr && awaddr_reg == `SPM_TX_OFS && wstrb_reg[0] && !pend_reg;
  wire wr_clr = do_wr && awaddr_reg == `SPM_STAT_OFS && wstrb_reg[0];
  wire baud_ok = wmerge_div[16:0] >= DIV_MIN && wmerge_div[16:0] <= DIV_MAX && wmerge_div[31:17] == 15'h0;
  wire stn_ok = wmerge_stn != 8'h00 && wmerge_stn <= stn_max;
  wire wr_hit = awaddr_reg inside {`SPM_CFG_OFS, `SPM_BAUD_OFS, `SPM_DLY_OFS, `SPM_TX_OFS, `SPM_RX_OFS,
                                   `SPM_STAT_OFS, `SPM_STN_OFS};
  wire rd_take = arready_reg && s_axi_arvalid;
  wire rd_rx = rd_take && s_axi_araddr == `SPM_RX_OFS;
  wire [31:0] status = {24'h0, rts_reg, paused_reg, ferr_reg, perr_reg, err_reg, rx_valid_reg, pend_reg, master_reg};
  wire rd_hit = s_axi_araddr inside {`SPM_CFG_OFS, `SPM_BAUD_OFS, `SPM_DLY_OFS, `SPM_TX_OFS, `SPM_RX_OFS,
                                     `SPM_STAT_OFS, `SPM_STN_OFS};
  wire [31:0] rd_mux = (s_axi_araddr == `SPM_CFG_OFS) ? cfg_reg :
                       (s_axi_araddr == `SPM_BAUD_OFS) ? {15'h0, div_reg} :
                       (s_axi_araddr == `SPM_DLY_OFS) ? dly_reg :
                       (s_axi_araddr == `SPM_TX_OFS) ? {23'h0, last_reg, tx_data_reg} :
                       (s_axi_araddr == `SPM_RX_OFS) ? {23'h0, rx_valid_reg, rx_data_reg} :
                       (s_axi_araddr == `SPM_STAT_OFS) ? status :
                       (s_axi_araddr == `SPM_STN_OFS) ? {24'h0, stn_reg} : 32'h0;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign txd = txd_reg;
  assign rts_out = rts_reg;

  // ---------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, aw_got_reg, w_got_reg} <= 7'h00;
      {bresp_reg, rresp_reg} <= 4'h0;
      {awaddr_reg, wdata_reg, wstrb_reg, rdata_reg} <= 76'h0;
    end else if (ce) begin
      if (awready_reg && s_axi_awvalid) begin
        awready_reg <= 1'h0;
        aw_got_reg <= 1'h1;
        awaddr_reg <= s_axi_awaddr;
      end else if (!aw_got_reg && !bvalid_reg) awready_reg <= 1'h1;
      if (wready_reg && s_axi_wvalid) begin
        wready_reg <= 1'h0;
        w_got_reg <= 1'h1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (!w_got_reg && !bvalid_reg) wready_reg <= 1'h1;
      if (do_wr) begin
        {aw_got_reg, w_got_reg} <= 2'h0;
        bvalid_reg <= 1'h1;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
      end else if (bvalid_reg && s_axi_bready) bvalid_reg <= 1'h0;
      if (rd_take) begin
        arready_reg <= 1'h0;
        rvalid_reg <= 1'h1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid_reg && s_axi_rready) rvalid_reg <= 1'h0;
      else if (!rvalid_reg) arready_reg <= 1'h1;
    end
  end

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= `SPM_CFG_RST;
      dly_reg <= `SPM_DLY_RST;
      div_reg <= DIV_DEF;
      stn_reg <= `SPM_STN_RST;
    end else if (ce) begin
      if (wr_cfg) cfg_reg <= wmerge_cfg & `SPM_CFG_MASK;
      if (wr_dly) dly_reg <= wmerge_dly & `SPM_DLY_MASK;
      if (wr_baud && baud_ok) div_reg <= wmerge_div[16:0];
      if (wr_stn && stn_ok) stn_reg <= wmerge_stn;
    end
  end

  // ---------------------------------------------
  // Transaction sequencer
  // ---------------------------------------------
  wire wait_zero = wait_reg == 32'h0;
  wire ms_tick = ms_cnt_reg >= MS_LAST;
  wire tick = (st_reg == SPM_WAIT && is_raw) || ms_tick;
  wire tx_busy = tx_left_reg != 4'h0;
  wire tx_fin = tx_busy && tx_tmr_reg == 17'h0 && tx_left_reg == 4'h1;
  wire [7:0] tx_char = ascii ? hex_char(nib_reg ? tx_data_reg[3:0] : tx_data_reg[7:4]) : tx_data_reg;
  wire tx_load = st_reg == SPM_SEND && !tx_busy && pend_reg && !(xon_en && paused_reg)
                 && (!rtsfc || cts_in);
  wire rx_deliver;
  wire [31:0] wait_load = (st_next == SPM_RTS_ON) ? {24'h0, dly_reg[`SPM_DLY_ON]} :
                          (st_next == SPM_RTS_OFF) ? {24'h0, dly_reg[`SPM_DLY_OFF]} : tmo_cnt;

  // Protocol field holds a single protocol, so master mode never auto-detects
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      SPM_IDLE: if (pend_reg) st_next = SPM_RTS_ON;
      SPM_RTS_ON: if (wait_zero) st_next = SPM_SEND;
      SPM_SEND: if (!pend_reg && last_reg && !tx_busy) st_next = SPM_RTS_OFF;
      SPM_RTS_OFF: if (wait_zero) st_next = SPM_WAIT;
      SPM_WAIT: if (rx_deliver || tmo_off || wait_zero) st_next = SPM_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= SPM_IDLE;
      {wait_reg, ms_cnt_reg} <= 48'h0;
      {rts_reg, master_reg} <= 2'h0;
    end else if (ce) begin
      st_reg <= st_next;
      ms_cnt_reg <= ms_tick ? 16'h0 : 16'(ms_cnt_reg + 16'h1);
      if (st_next != st_reg) wait_reg <= wait_load;
      else if (tick && !wait_zero) wait_reg <= 32'(wait_reg - 32'h1);
      rts_reg <= st_next inside {SPM_RTS_ON, SPM_SEND, SPM_RTS_OFF};
      master_reg <= st_next != SPM_IDLE;
    end
  end

  // ---------------------------------------------
  // Transmitter
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pend_reg, last_reg, nib_reg} <= 3'h0;
      tx_data_reg <= 8'h00;
    end else if (ce) begin
      if (wr_tx) begin
        tx_data_reg <= wdata_reg[7:0];
        last_reg <= wdata_reg[`SPM_TX_LAST];
        pend_reg <= 1'h1;
      end else if (tx_fin && ascii && !nib_reg) nib_reg <= 1'h1;
      else if (tx_fin) begin
        nib_reg <= 1'h0;
        pend_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_reg <= 12'hFFF;
      tx_left_reg <= 4'h0;
      tx_tmr_reg <= 17'h0;
      txd_reg <= 1'h1;
    end else if (ce) begin
      if (tx_load) begin
        tx_sh_reg <= frame(tx_char, data7, par_on, par_odd);
        tx_left_reg <= frame_bits;
        tx_tmr_reg <= 17'(div_reg - 17'h1);
        txd_reg <= 1'h0;
      end else if (tx_busy && tx_tmr_reg == 17'h0) begin
        tx_tmr_reg <= 17'(div_reg - 17'h1);
        tx_left_reg <= 4'(tx_left_reg - 4'h1);
        tx_sh_reg <= {1'h1, tx_sh_reg[11:1]};
        txd_reg <= (tx_left_reg == 4'h1) ? 1'h1 : tx_sh_reg[1];
      end else if (tx_busy) tx_tmr_reg <= 17'(tx_tmr_reg - 17'h1);
    end
  end

  // ---------------------------------------------
  // Receiver
  // ---------------------------------------------
  wire rx_block = echo && rts_reg;
  wire rx_samp = rx_busy_reg && rx_tmr_reg == 17'h0;
  wire [11:0] rx_frm = rx_sh_reg >> (4'(4'hC - frame_bits));
  wire [7:0] rx_byte = data7 ? {1'h0, rx_frm[7:1]} : rx_frm[8:1];
  wire par_bad = par_on && rx_frm[data7 ? 8 : 9] != par_bit(rx_byte, data7, par_odd);
  wire frm_bad = !rx_frm[frame_bits - 4'h1];
  wire flow_char = xon_en && (rx_byte == `SPM_XON_CHAR || rx_byte == `SPM_XOFF_CHAR);
  assign rx_deliver = rx_done_reg && !flow_char && !(ascii && !rnib_reg);
  wire [7:0] rx_word = ascii ? {rhi_reg, hex_val(rx_byte)} : rx_byte;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rx_busy_reg, rx_done_reg} <= 2'h0;
      rx_tmr_reg <= 17'h0;
      rx_left_reg <= 4'h0;
      rx_sh_reg <= 12'h000;
    end else if (ce) begin
      rx_done_reg <= rx_samp && rx_left_reg == 4'h1;
      if (!rx_busy_reg && !rxd && !rx_block) begin
        rx_busy_reg <= 1'h1;
        rx_tmr_reg <= div_reg >> 1;
        rx_left_reg <= frame_bits;
      end else if (rx_samp) begin
        rx_tmr_reg <= 17'(div_reg - 17'h1);
        rx_left_reg <= 4'(rx_left_reg - 4'h1);
        rx_sh_reg <= {rxd, rx_sh_reg[11:1]};
        if ((rx_left_reg == frame_bits && rxd) || rx_left_reg == 4'h1) rx_busy_reg <= 1'h0;
      end else if (rx_busy_reg) rx_tmr_reg <= 17'(rx_tmr_reg - 17'h1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rx_valid_reg, rnib_reg, paused_reg, err_reg, perr_reg, ferr_reg} <= 6'h00;
      rx_data_reg <= 8'h00;
      rhi_reg <= 4'h0;
    end else if (ce) begin
      if (rx_done_reg && flow_char) paused_reg <= rx_byte == `SPM_XOFF_CHAR;
      else if (!xon_en) paused_reg <= 1'h0;
      if (rx_done_reg && !flow_char && ascii) rnib_reg <= !rnib_reg;
      if (rx_done_reg && !flow_char && ascii && !rnib_reg) rhi_reg <= hex_val(rx_byte);
      if (rx_deliver) rx_data_reg <= rx_word;
      rx_valid_reg <= rx_deliver || (rx_valid_reg && !rd_rx);
      err_reg <= (st_reg == SPM_WAIT && wait_zero && !tmo_off && !rx_deliver)
                 || (err_reg && !(wr_clr && wdata_reg[`SPM_ST_ERR]));
      perr_reg <= (rx_done_reg && par_bad) || (perr_reg && !(wr_clr && wdata_reg[`SPM_ST_PERR]));
      ferr_reg <= (rx_done_reg && frm_bad) || (ferr_reg && !(wr_clr && wdata_reg[`SPM_ST_FERR]));
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_timeout;
    st_reg == SPM_WAIT && wait_zero && !tmo_off && !rx_deliver;
  endsequence
  sequence s_off_done;
    st_reg == SPM_RTS_OFF && wait_zero;
  endsequence

  rts_on_idle_a: assert property (st_reg == SPM_RTS_ON |-> rts_reg && txd_reg && !tx_busy)
    else $error("data sent during RTS on-delay");
  rts_off_drop_a: assert property ($fell(rts_reg) |-> $past(st_reg == SPM_RTS_OFF && wait_zero))
    else $error("RTS dropped before off-delay ended");
  tmo_error_a: assert property (s_timeout |=> err_reg && st_reg == SPM_IDLE && !master_reg)
    else $error("timeout not flagged or not idle");
  tmo_load_a: assert property (s_off_done ##0 proto == SPM_PROTO_MODBUS |=>
      wait_reg == 32'(`SPM_MB_TMO_MS * mult))
    else $error("wrong response timeout loaded");
  slave_idle_a: assert property (st_reg == SPM_IDLE ##1 st_reg == SPM_IDLE |-> !master_reg)
    else $error("master while idle");
  baud_range_a: assert property (div_reg >= DIV_MIN && div_reg <= DIV_MAX)
    else $error("bit rate out of range");
  stn_range_a: assert property (stn_reg != 8'h00 && stn_reg <= `SPM_STN_MAX_MB)
    else $error("station out of range");
  stop_bit_a: assert property (tx_busy && (tx_left_reg == 4'h1 || (stop2 && tx_left_reg == 4'h2)) |-> txd_reg)
    else $error("stop bit not high");
  parity_err_a: assert property (rx_done_reg && par_bad |=> perr_reg)
    else $error("parity error missed");
  raw_seven_a: assert property (rx_deliver && data7 |=> !rx_data_reg[7])
    else $error("eighth bit kept in seven-bit mode");
  xoff_hold_a: assert property (tx_load |-> !(xon_en && paused_reg))
    else $error("sent while paused");
  cts_gate_a: assert property (tx_load |-> !rtsfc || cts_in)
    else $error("sent without clear to send");
  echo_drop_a: assert property (rx_block && !rx_busy_reg |=> !rx_busy_reg)
    else $error("own echo received");
endmodule : spm_serial_port

// *** test/spm_remote_station.sv ***
`timescale 1ns/10ps
// ---------------------------------------------
// Remote station on the serial line
// ---------------------------------------------
module spm_remote_station (
  input wire logic aclk,
  input wire logic [16:0] bit_cyc,
  input wire logic txd,
  output logic rxd,
  input wire logic resp_go,
  input wire logic [8:0] resp_bits,
  output logic [10:0] frame,
  output logic [7:0] frame_cnt
);
  int i;
  int j;
  logic [11:0] sh;
  initial begin
    frame_cnt = 8'h00;
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge aclk);
      for (i = 0; i < 11; i++) begin
        repeat (bit_cyc) @(posedge aclk);
        frame[i] = txd;
      end
      frame_cnt <= frame_cnt + 8'h01;
    end
  end
  // Answer at the same bit time as the port
  initial begin
    rxd = 1'b1;
    forever begin
      @(posedge aclk);
      if (resp_go) begin
        sh = {2'h3, resp_bits, 1'b0};
        for (j = 0; j < 12; j++) begin
          rxd <= sh[j];
          repeat (bit_cyc) @(posedge aclk);
        end
      end
    end
  end
endmodule : spm_remote_station

// *** test/testbench.sv ***
`timescale 1ns/10ps
`include "spm_regs.svh"
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, cts_in = 1'b1, resp_go = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxd, txd, rts_out, st, d7;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, par, pr;
  logic [8:0] resp_bits = 9'h0;
  logic [10:0] frame, f;
  logic [7:0] frame_cnt, fc, b;
  int err_count = 0, n_tests = 0, cnt, k, nb;
  time t0;
  always #20 aclk = ~aclk;
  spm_serial_port #(.MS_CYCLES(20)) spm_serial_port_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxd, .cts_in, .txd, .rts_out);
  spm_remote_station spm_remote_station_inst (.aclk, .bit_cyc(17'h000DA), .txd, .rxd, .resp_go, .resp_bits,
    .frame, .frame_cnt);
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 5000) begin
      err_count++;
      give_verdict();
    end
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rrd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rrd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rrd(a);
    check(rd, e);
  endtask : rchk
  function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic [1:0] p, input logic n7);
    logic pb;
    pb = ^(d & {~n7, 7'h7F}) ^ (p == 2'h2);
    exp_frame = n7 ? {4'hF, d[6:0]} : {3'h7, d};
    if (p == 2'h1 || p == 2'h2) exp_frame[n7 ? 7 : 8] = pb;
  endfunction : exp_frame
  // ---------------------------------------------
  // Stimulus
  // ---------------------------------------------
  initial begin
    rd = $urandom(75);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`SPM_CFG_OFS, `SPM_CFG_RST);
    rchk(`SPM_BAUD_OFS, 32'h516);
    rchk(`SPM_DLY_OFS, `SPM_DLY_RST);
    rchk(`SPM_STAT_OFS, 32'h0);
    rchk(8'h1C, 32'h0);
    check(rsp, 2'h2);
    wr(`SPM_STN_OFS, 32'h5B);
    rchk(`SPM_STN_OFS, 32'h1);
    wr(`SPM_STN_OFS, 32'h5A);
    rchk(`SPM_STN_OFS, 32'h5A);
    wr(`SPM_STN_OFS, 32'h1);
    wr(`SPM_BAUD_OFS, 32'hDA);
    wr(`SPM_DLY_OFS, 32'h0001_0102);
    for (k = 0; k < 4; k++) begin
      par = 2'(k % 3);
      st = 1'($urandom);
      d7 = (k == 2) && 1'($urandom);
      pr = (k == 1) ? 2'h1 : (k == 2) ? 2'h2 : 2'h0;
      b = 8'($urandom);
      nb = 10 + (par != 2'h0) + st - d7;
      cts_in <= k != 0;
      wr(`SPM_CFG_OFS, {23'h0, k == 0, 1'b0, d7, st, par, 1'b0, pr});
      wr(`SPM_TX_OFS, {23'h0, 1'b1, b});
      cnt = 0;
      while (!rts_out) tick(cnt);
      cnt = 0;
      while (txd) begin
        tick(cnt);
        if (cnt == 50) cts_in <= 1'b1;
      end
      check(k == 0 ? cnt == 52 : cnt >= 20 && cnt <= 44, 1);
      fc = frame_cnt;
      cnt = 0;
      while (rts_out) tick(cnt);
      check(cnt >= nb * 218 && cnt <= nb * 218 + 30, 1);
      t0 = $time;
      rrd(`SPM_STAT_OFS);
      check(rd[0], 1'b1);
      cnt = 0;
      while (frame_cnt == fc) tick(cnt);
      check(frame, exp_frame(b, par, d7));
      if (k < 3) begin
        b = 8'($urandom);
        f = exp_frame(b, par, d7);
        resp_bits <= f[8:0];
        resp_go <= 1'b1;
        @(posedge aclk);
        resp_go <= 1'b0;
        cnt = 0;
        do begin
          rrd(`SPM_RX_OFS);
          cnt++;
        end while (!rd[8] && cnt < 2000);
        if (!rd[8]) begin
          err_count++;
          give_verdict();
        end
        check(rd[8:0], {1'b1, b & {~d7, 7'h7F}});
        rchk(`SPM_STAT_OFS, 32'h0);
      end else begin
        cnt = 0;
        do begin
          rrd(`SPM_STAT_OFS);
          cnt++;
        end while (!rd[3] && cnt < 9000);
        if (!rd[3]) begin
          err_count++;
          give_verdict();
        end
        cnt = int'(($time - t0) / 40);
        check(cnt >= 15980 && cnt <= 16040, 1);
        check(rd[1:0], 2'h0);
        wr(`SPM_STAT_OFS, 32'h8);
        rchk(`SPM_STAT_OFS, 32'h0);
      end
    end
    give_verdict();
  end
endmodule : testbench
